// ---- core/isp_prog_host.sv ----
`timescale 1ns/10ps
module isp_prog_host
  import isp_prog_pkg::*;
#(
  parameter int HALF_CYC    = CORE_PH_CYC,
  parameter int RST_CYC     = RST_PULSE_CYC,
  parameter int PWRUP_CYC_P = PWRUP_CYC,
  parameter int FLASH_CYC_P = WD_FLASH_CYC,
  parameter int FUSE_CYC_P  = WD_FUSE_CYC,
  parameter int EE_CYC_P    = WD_EE_CYC,
  parameter int ERASE_CYC_P = WD_ERASE_CYC,
  parameter int TRIES       = MAX_TRIES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_req_valid,
  input  wire req_s i_req,
  input  wire logic i_miso,
  output logic      o_cmd_ready,
  output logic      o_rsp_valid,
  output rsp_s      o_rsp,
  output logic      o_in_prog,
  output logic      o_tgt_rst_n,
  output logic      o_sck,
  output logic      o_mosi
);
  // Phases must outlast the target's minimum core cycles; the reset pulse must last at least two core cycles
  if (HALF_CYC < 5 || HALF_CYC * CORE_KHZ <= CORE_MIN_PH * SYS_KHZ ||
      RST_CYC < 1 || RST_CYC * CORE_KHZ < 2 * SYS_KHZ ||
      PWRUP_CYC_P < 1 || TRIES < 1 || TRIES > 15 ||
      FLASH_CYC_P < 1 || FUSE_CYC_P < 1 || EE_CYC_P < 1 || ERASE_CYC_P < 1 ||
      FLASH_CYC_P >= 2 ** CNT_W || FUSE_CYC_P >= 2 ** CNT_W ||
      PWRUP_CYC_P >= 2 ** CNT_W || ERASE_CYC_P >= 2 ** CNT_W || EE_CYC_P >= 2 ** CNT_W) begin : g_chk
    $error("isp_prog_host: parameter out of range");
  end

  typedef struct packed {
    state_e      st;
    logic [CNT_W-1:0] cnt;
    logic [5:0]  bitn;
    logic [31:0] sh;
    logic [31:0] rx;
    logic [CNT_W-1:0] wt;
    logic [3:0]  tries;
    logic        en_cmd;
    logic        in_prog;
    logic        rst_n;
    logic        sck;
    logic        mosi;
    logic        ms1;
    logic        ms2;
    logic        ms3;
    logic        miso;
    logic        rdy;
    logic        rsp_valid;
    rsp_s        rsp;
  } host_s;

  host_s s;
  host_s n;
  logic  rst_q1;
  logic  rst_q2;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Minimum wait after a write-class command, zero for anything else
  function automatic logic [CNT_W-1:0] wait_of(input logic [31:0] w);
    logic [CNT_W-1:0] r;
    r = '0;
    if (w[31:24] == B1_PAGE_WR) r = CNT_W'(FLASH_CYC_P);
    else if (w[31:24] == B1_EE_WR) r = CNT_W'(EE_CYC_P);
    else if (w[31:24] == B1_PROG) begin
      if (w[23:21] == B2_ERASE) r = CNT_W'(ERASE_CYC_P);
      else if (w[23:21] == B2_LOCK) r = CNT_W'(FUSE_CYC_P);
      else if (w[23:16] == B2_FUSE_LO || w[23:16] == B2_FUSE_HI) r = CNT_W'(FUSE_CYC_P);
    end
    return r;
  endfunction : wait_of

  always_comb begin
    n = s;
    n.ms1 = i_miso;
    n.ms2 = s.ms1;
    n.ms3 = s.ms2;
    if (s.ms2 == s.ms3) n.miso = s.ms3;
    n.rsp_valid = 1'b0;
    n.cnt = (s.cnt == '0) ? '0 : s.cnt - 1'b1;
    unique case (s.st)
      ST_IDLE: begin
        if (i_req_valid) begin
          n.rsp_valid = 1'b1;
          n.rsp = '{ok: 1'b1, data: 8'h00};
          unique case (i_req.op)
            OP_ENTER: begin
              n.rsp_valid = 1'b0;
              n.rst_n = 1'b0;
              n.sck = 1'b0;
              n.in_prog = 1'b0;
              n.tries = 4'(TRIES - 1);
              n.st = ST_PWRUP;
              n.cnt = CNT_W'(PWRUP_CYC_P - 1);
            end
            OP_XFER: begin
              if (s.in_prog) begin
                n.rsp_valid = 1'b0;
                n.en_cmd = 1'b0;
                n.sh = i_req.word;
                n.wt = wait_of(i_req.word);
                n.bitn = '0;
                n.st = ST_LO;
                n.cnt = CNT_W'(HALF_CYC - 1);
              end else begin
                n.rsp.ok = 1'b0;
              end
            end
            OP_LEAVE: begin
              n.rst_n = 1'b1;
              n.in_prog = 1'b0;
            end
            default: n.rsp.ok = 1'b0;
          endcase
        end
      end
      ST_PWRUP: begin
        if (s.cnt == '0) begin
          n.en_cmd = 1'b1;
          n.sh = CMD_ENABLE;
          n.wt = '0;
          n.bitn = '0;
          n.st = ST_LO;
          n.cnt = CNT_W'(HALF_CYC - 1);
        end
      end
      ST_LO: begin
        n.mosi = s.sh[31];
        if (s.cnt == '0) begin
          n.sck = 1'b1;
          n.st = ST_HI;
          n.cnt = CNT_W'(HALF_CYC - 1);
        end
      end
      ST_HI: begin
        if (s.cnt == '0) begin
          n.rx = {s.rx[30:0], s.miso};
          n.sh = {s.sh[30:0], 1'b0};
          n.sck = 1'b0;
          n.bitn = s.bitn + 1'b1;
          n.st = ST_LO;
          n.cnt = CNT_W'(HALF_CYC - 1);
          if (s.bitn == 6'(CMD_BITS - 1)) begin
            n.st = ST_IDLE;
            if (s.en_cmd) begin
              if (n.rx[15:8] == ECHO_BYTE) begin
                n.in_prog = 1'b1;
                n.rsp_valid = 1'b1;
                n.rsp = '{ok: 1'b1, data: n.rx[15:8]};
              end else if (s.tries != '0) begin
                n.tries = s.tries - 1'b1;
                n.rst_n = 1'b1;
                n.st = ST_RSTP;
                n.cnt = CNT_W'(RST_CYC - 1);
              end else begin
                n.rsp_valid = 1'b1;
                n.rsp = '{ok: 1'b0, data: n.rx[15:8]};
              end
            end else begin
              // Fourth byte carries read data
              n.rsp_valid = 1'b1;
              n.rsp = '{ok: 1'b1, data: n.rx[7:0]};
              if (s.wt != '0) begin
                n.st = ST_WAIT;
                n.cnt = s.wt - 1'b1;
              end
            end
          end
        end
      end
      ST_RSTP: begin
        if (s.cnt == '0) begin
          n.rst_n = 1'b0;
          n.st = ST_PWRUP;
          n.cnt = CNT_W'(PWRUP_CYC_P - 1);
        end
      end
      ST_WAIT: begin
        if (s.cnt == '0) n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    n.rdy = (n.st == ST_IDLE);
  end

  always_ff @(posedge i_sys_clk or negedge rst_q2) begin
    if (!rst_q2) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.rst_n <= 1'b1;
      s.rdy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign o_cmd_ready = s.rdy;
  assign o_rsp_valid = s.rsp_valid;
  assign o_rsp       = s.rsp;
  assign o_in_prog   = s.in_prog;
  assign o_tgt_rst_n = s.rst_n;
  assign o_sck       = s.sck;
  assign o_mosi      = s.mosi;

  // Checking helpers
  logic             sck_d;
  logic [CNT_W-1:0] ph;
  logic [CNT_W-1:0] rlow;
  logic [CNT_W-1:0] rhigh;
  logic [6:0]       edges;
  always_ff @(posedge i_sys_clk or negedge rst_q2) begin
    if (!rst_q2) begin
      sck_d <= 1'b0;
      ph <= '0;
      rlow <= '0;
      rhigh <= '0;
      edges <= '0;
    end else begin
      sck_d <= s.sck;
      ph <= (s.sck != sck_d) ? CNT_W'(1) : ph + 1'b1;
      rlow <= s.rst_n ? '0 : ((&rlow) ? rlow : rlow + 1'b1);
      rhigh <= !s.rst_n ? '0 : ((&rhigh) ? rhigh : rhigh + 1'b1);
      if (s.st == ST_IDLE || s.st == ST_PWRUP) edges <= '0;
      else if (s.sck && !sck_d) edges <= edges + 1'b1;
    end
  end

  a_sck_phase_min: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    (s.sck != sck_d) |-> ph >= CNT_W'(HALF_CYC)) else $error("serial clock phase too short");
  a_mosi_setup: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    $changed(s.mosi) |-> !s.sck && !$past(s.sck)) else $error("data changed near clock rise");
  a_rx_on_fall: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    $changed(s.rx) |-> $fell(s.sck)) else $error("read data taken off the falling edge");
  a_pwrup_low: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    s.st == ST_PWRUP |-> !s.sck && !s.rst_n) else $error("clock or reset high in power-up");
  a_enable_delay: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    $rose(s.sck) |-> rlow >= CNT_W'(PWRUP_CYC_P)) else $error("enable sent too early");
  a_rst_pulse: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    ($fell(s.rst_n) && $past(s.st) == ST_RSTP) |-> rhigh >= CNT_W'(RST_CYC))
    else $error("reset pulse too short");
  a_cmd_32_clk: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    ($past(s.st) == ST_HI && s.st != ST_LO && s.st != ST_HI) |-> edges == 7'(CMD_BITS))
    else $error("command not 32 clocks long");
  a_echo_ok: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    ($rose(s.in_prog)) |-> s.rx[15:8] == ECHO_BYTE && s.rsp_valid) else $error("enable without echo");
  a_wait_quiet: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    s.st == ST_WAIT |-> !s.sck && !s.rdy) else $error("activity during write wait");
  a_write_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    ($past(s.st) == ST_HI && s.st == ST_WAIT) |-> !s.rdy [*8]) else $error("write wait cut short");
  a_refuse: assert property (@(posedge i_sys_clk) disable iff (!rst_q2)
    ($rose(s.sck) && !s.en_cmd) |-> s.in_prog) else $error("command sent before enable");
endmodule : isp_prog_host

// ---- core/isp_prog_pkg.sv ----
package isp_prog_pkg;
  localparam int SYS_KHZ       = 10000;
  localparam int CORE_KHZ      = 1000;
  localparam int FAST_CORE_KHZ = 12000;
  localparam int T_PWRUP_US    = 20000;
  localparam int T_WD_FLASH_US = 4500;
  localparam int T_WD_FUSE_US  = 4500;
  localparam int T_WD_EE_US    = 9000;
  localparam int T_WD_ERASE_US = 9000;
  localparam int PWRUP_CYC     = T_PWRUP_US * (SYS_KHZ / 1000);
  localparam int WD_FLASH_CYC  = T_WD_FLASH_US * (SYS_KHZ / 1000);
  localparam int WD_FUSE_CYC   = T_WD_FUSE_US * (SYS_KHZ / 1000);
  localparam int WD_EE_CYC     = T_WD_EE_US * (SYS_KHZ / 1000);
  localparam int WD_ERASE_CYC  = T_WD_ERASE_US * (SYS_KHZ / 1000);
  localparam int CORE_MIN_PH   = (CORE_KHZ < FAST_CORE_KHZ) ? 2 : 3;
  // Strictly longer than the minimum core cycles per clock phase
  localparam int CORE_PH_CYC   = (CORE_MIN_PH * SYS_KHZ + CORE_KHZ - 1) / CORE_KHZ + 1;
  localparam int RST_PULSE_CYC = (2 * SYS_KHZ + CORE_KHZ - 1) / CORE_KHZ;
  localparam int MAX_TRIES     = 4;
  localparam int CMD_BITS      = 32;
  localparam int CNT_W         = 24;
  localparam logic [31:0] CMD_ENABLE = 32'hac53_0000;
  localparam logic [7:0]  ECHO_BYTE  = 8'h53;
  localparam logic [7:0]  B1_PROG    = 8'hac;
  localparam logic [7:0]  B1_PAGE_WR = 8'h4c;
  localparam logic [7:0]  B1_EE_WR   = 8'hc0;
  localparam logic [2:0]  B2_ERASE   = 3'h4;
  localparam logic [2:0]  B2_LOCK    = 3'h7;
  localparam logic [7:0]  B2_FUSE_LO = 8'ha0;
  localparam logic [7:0]  B2_FUSE_HI = 8'ha8;

  typedef enum logic [1:0] {
    OP_ENTER = 2'h0,
    OP_XFER  = 2'h1,
    OP_LEAVE = 2'h2
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PWRUP = 3'h1,
    ST_LO    = 3'h2,
    ST_HI    = 3'h3,
    ST_RSTP  = 3'h4,
    ST_WAIT  = 3'h5
  } state_e;

  typedef struct packed {
    op_e         op;
    logic [31:0] word;
  } req_s;

  typedef struct packed {
    logic       ok;
    logic [7:0] data;
  } rsp_s;
endpackage : isp_prog_pkg

// ---- testbench/isp_target_model.sv ----
`timescale 1ns/10ps
module isp_target_model
  import isp_prog_pkg::*;
(
  input  wire logic i_rst_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_bad_echo,
  output logic      o_miso
);
  logic [31:0] sh;
  logic [7:0]  ob;
  logic [7:0]  f_lo;
  logic [7:0]  f_hi;
  logic [7:0]  lck;
  logic [15:0] fl [64];
  logic [15:0] pb [32];
  logic [7:0]  ee [64];
  logic        prog;
  int          n;

  initial begin
    o_miso = 1'b1;
    f_lo   = 8'h11;
    f_hi   = 8'h22;
    lck    = 8'hff;
    ob     = 8'h00;
    prog   = 1'b0;
    n      = 0;
  end

  // Reset high ends the session and drops programming mode
  always @(posedge i_sck or posedge i_rst_n) begin
    if (i_rst_n) begin
      n    = 0;
      prog = 1'b0;
    end else begin
      sh = {sh[30:0], i_mosi};
      n  = (n + 1) % CMD_BITS;
      if (n == 16) ob = sh[7:0] ^ {8{i_bad_echo}};
      if (n == 24 && prog) begin
        case (sh[23:16])
          8'h20:   ob = fl[sh[5:0]][7:0];
          8'h28:   ob = fl[sh[5:0]][15:8];
          8'ha0:   ob = ee[sh[5:0]];
          8'h50:   ob = f_lo;
          8'h58:   ob = sh[11] ? f_hi : lck;
          default: ob = 8'h00;
        endcase
      end
      if (n == 0) begin
        if (sh[31:16] == CMD_ENABLE[31:16]) prog = 1'b1;
        else if (prog) begin
          if (sh[31:24] == B1_PROG && sh[23:21] == B2_ERASE) begin
            foreach (fl[i]) fl[i] = 16'hffff;
            foreach (ee[i]) ee[i] = 8'hff;
          end
          if (sh[31:24] == B1_PROG && sh[23:21] == B2_LOCK) lck = sh[7:0];
          if (sh[31:16] == {B1_PROG, B2_FUSE_LO}) f_lo = sh[7:0];
          if (sh[31:16] == {B1_PROG, B2_FUSE_HI}) f_hi = sh[7:0];
          if (sh[31:24] == 8'h40) pb[sh[12:8]][7:0] = sh[7:0];
          if (sh[31:24] == 8'h48) pb[sh[12:8]][15:8] = sh[7:0];
          if (sh[31:24] == B1_PAGE_WR) foreach (pb[i]) fl[{sh[13], i[4:0]}] = pb[i];
          if (sh[31:24] == B1_EE_WR) ee[sh[13:8]] = sh[7:0];
        end
      end
    end
  end

  // Released line shows the inverse of its last level
  always @(negedge i_sck or posedge i_rst_n) begin
    if (i_rst_n) o_miso = ~o_miso;
    else begin
      o_miso = ob[7];
      ob     = {ob[6:0], 1'b0};
    end
  end
endmodule : isp_target_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import isp_prog_pkg::*;
;
  localparam int HALF = CORE_PH_CYC;
  logic sys_clk = 1'b0;
  logic rstn;
  logic req_valid;
  logic bad_echo;
  req_s req;
  rsp_s rsp;
  logic rdy, rsp_valid, in_prog, tgt_rst_n, sck, mosi, miso, sck_q, mosi_q;
  int   errors, checks, cyc, ph, pulses;

  always #50 sys_clk = ~sys_clk;

  // Counts target reset pulses made by enable retries
  always @(posedge tgt_rst_n) pulses++;

  isp_prog_host #(.PWRUP_CYC_P(100), .FLASH_CYC_P(40), .FUSE_CYC_P(40), .EE_CYC_P(60),
    .ERASE_CYC_P(60)) isp_prog_host_inst (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_req_valid(req_valid), .i_req(req),
    .i_miso(miso), .o_cmd_ready(rdy), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .o_in_prog(in_prog), .o_tgt_rst_n(tgt_rst_n), .o_sck(sck), .o_mosi(mosi));

  isp_target_model isp_target_model_inst (.i_rst_n(tgt_rst_n), .i_sck(sck),
    .i_mosi(mosi), .i_bad_echo(bad_echo), .o_miso(miso));

  task automatic results;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // A hang is caught by the global cycle ceiling
  task automatic xfer(input op_e op, input logic [31:0] w, output rsp_s r);
    @(negedge sys_clk);
    while (rdy !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req       <= {op, w};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
    end while (rsp_valid !== 1'b1);
    r = rsp;
  endtask : xfer

  // High-phase lengths and data stability while the serial clock is high
  always @(negedge sys_clk) begin
    if (sck !== sck_q) begin
      if (sck_q === 1'b1) chk(ph, HALF);
      ph = 1;
    end else ph = ph + 1;
    if (sck_q === 1'b1 && sck === 1'b1) chk(mosi, mosi_q);
    sck_q  = sck;
    mosi_q = mosi;
    cyc++;
    if (cyc == 50000) begin
      errors++;
      results();
    end
  end

  task automatic t_refuse;
    rsp_s r;
    xfer(OP_XFER, 32'h2000_0300, r);
    chk(r.ok, 1'b0);
    xfer(op_e'(2'h3), 32'h0, r);
    chk(r.ok, 1'b0);
  endtask : t_refuse

  task automatic t_enter;
    rsp_s r;
    @(posedge sys_clk) bad_echo <= 1'b1;
    pulses = 0;
    xfer(OP_ENTER, CMD_ENABLE, r);
    chk({r.ok, in_prog}, 2'b00);
    chk(pulses, MAX_TRIES - 1);
    @(posedge sys_clk) bad_echo <= 1'b0;
    xfer(OP_ENTER, CMD_ENABLE, r);
    chk(r, {1'b1, ECHO_BYTE});
    chk(in_prog, 1'b1);
  endtask : t_enter

  task automatic t_flash;
    rsp_s r;
    xfer(OP_XFER, 32'h4000_03a5, r);
    xfer(OP_XFER, 32'h4800_035c, r);
    xfer(OP_XFER, 32'h4c00_0000, r);
    xfer(OP_XFER, 32'h2000_0300, r);
    chk(r, 9'h1a5);
    xfer(OP_XFER, 32'h2800_0300, r);
    chk(r, 9'h15c);
  endtask : t_flash

  task automatic t_ee;
    rsp_s r;
    int   k;
    logic [7:0] v [2] = '{8'h5a, 8'h96};
    foreach (v[i]) begin
      xfer(OP_XFER, {24'hc0_0005, v[i]}, r);
      k = 0;
      while (rdy !== 1'b1) begin
        @(negedge sys_clk);
        k++;
      end
      chk(k, 60);
      xfer(OP_XFER, 32'ha000_0500, r);
      chk(r, {1'b1, v[i]});
    end
  endtask : t_ee

  task automatic t_fuse;
    rsp_s r;
    logic [31:0] wr [3] = '{32'hace0_00fc, 32'haca0_003c, 32'haca8_00c3};
    logic [31:0] rd [3] = '{32'h5800_0000, 32'h5000_0000, 32'h5808_0000};
    foreach (wr[i]) begin
      xfer(OP_XFER, wr[i], r);
      xfer(OP_XFER, rd[i], r);
      chk(r.data, wr[i][7:0]);
    end
  endtask : t_fuse

  task automatic t_erase;
    rsp_s r;
    xfer(OP_XFER, 32'hac80_0000, r);
    xfer(OP_XFER, 32'h2000_0300, r);
    chk(r.data, 8'hff);
    xfer(OP_XFER, 32'ha000_0500, r);
    chk(r.data, 8'hff);
  endtask : t_erase

  task automatic t_leave;
    rsp_s r;
    xfer(OP_LEAVE, 32'h0, r);
    chk({r.ok, in_prog, tgt_rst_n}, 3'b101);
    xfer(OP_XFER, 32'ha000_0500, r);
    chk(r.ok, 1'b0);
  endtask : t_leave

  initial begin
    rstn      = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    bad_echo  = 1'b0;
    sck_q     = 1'b0;
    mosi_q    = 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_refuse();
    t_enter();
    t_flash();
    t_ee();
    t_fuse();
    t_erase();
    t_leave();
    results();
  end
endmodule : tb_top
